// file: hdl/sbl_params.svh
// Constants for the serial boot programming loader
`ifndef SBL_PARAMS_SVH
`define SBL_PARAMS_SVH
`define SBL_BOOT_ADDR      16'h0700
`define SBL_BLANK_WORD     16'hffff
`define SBL_CLEAR_WORD     16'h0000
`define SBL_CLK_HZ         50000000
`define SBL_BAUD           115200
`define SBL_BIT_CYC        (`SBL_CLK_HZ / `SBL_BAUD)
`define SBL_PULSE_NS       1000000
`define SBL_PULSE_CYC      ((`SBL_PULSE_NS / 20) - 1)
`define SBL_TIMEOUT_CYC    5000000
`define SBL_REQ_BYTE       8'h52
`define SBL_HOST_ACK_BYTE  8'h41
`define SBL_DEV_ACK_BYTE   8'h06
`define SBL_DEV_ERR_BYTE   8'h15
`define SBL_RX_TIME_CYC    2000
`endif

// file: hdl/sbl_pkg.sv
// Types for the serial boot programming loader
package sbl_pkg;
  typedef enum logic [9:0] {
    SBL_SEND_REQ  = 10'h001,
    SBL_WAIT_ACK  = 10'h002,
    SBL_GET_PAIR  = 10'h004,
    SBL_VPP_ON    = 10'h008,
    SBL_WRITE     = 10'h010,
    SBL_VPP_OFF   = 10'h020,
    SBL_READ      = 10'h040,
    SBL_REPLY     = 10'h080,
    SBL_RUN_APP   = 10'h100,
    SBL_TX_WAIT   = 10'h200
  } sbl_state_t;
endpackage

// file: hdl/sbl_boot_loader.sv
// Serial boot loader that programs one-time-programmable words
`timescale 1ns/1ns
`include "sbl_params.svh"
module sbl_boot_loader #(
  parameter int TIMEOUT_CYC = `SBL_TIMEOUT_CYC,
  parameter int PULSE_CYC   = `SBL_PULSE_CYC,
  parameter int BIT_CYC     = `SBL_BIT_CYC,
  parameter int MEM_AW      = 11
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  rxData,
  input  wire logic        rxValid,
  output logic             rxReady,
  output logic [7:0]       txData,
  output logic             txValid,
  input  wire logic        txReady,
  output logic             vppEnableOut_n,
  output logic [15:0]      bootVector,
  output logic             appStart,
  output logic             progError,
  input  wire logic [15:0] fetchAddr,
  output logic [15:0]      fetchWord,
  output logic             fetchNop
);
  sbl_pkg::sbl_state_t state_r;
  sbl_pkg::sbl_state_t retState_r;
  logic [15:0] tablePointer_r;
  logic [15:0] tableLatch_r;
  logic [15:0] readBack_r;
  logic [1:0]  byteCnt_r;
  logic [31:0] waitCnt_r;
  logic [15:0] baudDiv_r;
  logic        appStart_r;
  logic        progError_r;
  logic [15:0] mem [0:(1<<MEM_AW)-1];
  // Two-entry transmit buffer
  logic [7:0]  bufData_r [0:1];
  logic        bufWr_r;
  logic        bufRd_r;
  logic [1:0]  bufCnt_r;
  logic        pushValid;
  logic [7:0]  pushData;
  wire         bufFull  = (bufCnt_r == 2'd2);
  wire         bufEmpty = (bufCnt_r == 2'd0);
  wire         pushReady = !bufFull;
  wire         push     = pushValid && pushReady;
  wire         pop      = txValid && txReady;
  wire         rxTake   = rxValid && rxReady;
  wire [MEM_AW-1:0] memIdx   = tablePointer_r[MEM_AW-1:0];
  wire [MEM_AW-1:0] fetchIdx = fetchAddr[MEM_AW-1:0];
  wire         verifyOk = (readBack_r == tableLatch_r);
  wire         timedOut = (waitCnt_r >= 32'(TIMEOUT_CYC));
  wire         pulseDone = ((waitCnt_r + 32'h0000_0001) >= 32'(PULSE_CYC));
  // State decode
  wire         inSendReq = (state_r == sbl_pkg::SBL_SEND_REQ);
  wire         inTxWait  = (state_r == sbl_pkg::SBL_TX_WAIT);
  wire         inWaitAck = (state_r == sbl_pkg::SBL_WAIT_ACK);
  wire         inGetPair = (state_r == sbl_pkg::SBL_GET_PAIR);
  wire         inVppOn   = (state_r == sbl_pkg::SBL_VPP_ON);
  wire         inWrite   = (state_r == sbl_pkg::SBL_WRITE);
  wire         inVppOff  = (state_r == sbl_pkg::SBL_VPP_OFF);
  wire         inRead    = (state_r == sbl_pkg::SBL_READ);
  wire         inReply   = (state_r == sbl_pkg::SBL_REPLY);
  wire         inRunApp  = (state_r == sbl_pkg::SBL_RUN_APP);
  wire         ackSeen   = inWaitAck && rxTake && (rxData == `SBL_HOST_ACK_BYTE);
  wire         lastByte  = inGetPair && rxTake && (byteCnt_r == 2'd3);

  assign txValid     = !bufEmpty;
  assign txData      = bufData_r[bufRd_r];
  assign rxReady     = inWaitAck || inGetPair;
  assign bootVector  = `SBL_BOOT_ADDR;
  assign appStart    = appStart_r;
  assign progError   = progError_r;
  assign fetchWord   = mem[fetchIdx];
  assign fetchNop    = (mem[fetchIdx] == `SBL_CLEAR_WORD);
  assign pushValid   = inSendReq || inReply;
  assign pushData    = inSendReq ? `SBL_REQ_BYTE
                     : (verifyOk ? `SBL_DEV_ACK_BYTE : `SBL_DEV_ERR_BYTE);

  // Memory starts blank
  initial
  begin
    for (int i = 0; i < (1<<MEM_AW); i++)
      mem[i] = `SBL_BLANK_WORD;
  end

  // Plain always: the blank preload above writes the same array
  always @(posedge clk)
  begin
    if (inWrite && !vppEnableOut_n)
      mem[memIdx] <= mem[memIdx] & tableLatch_r;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bufWr_r  <= 1'b0;
      bufRd_r  <= 1'b0;
      bufCnt_r <= 2'd0;
    end
    else
    begin
      if (push)
        bufWr_r <= ~bufWr_r;
      if (pop)
        bufRd_r <= ~bufRd_r;
      bufCnt_r <= bufCnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  // One data register per buffer entry
  for (genvar gi = 0; gi < 2; gi++)
  begin : g_buf
    wire entryWr = push && (bufWr_r == 1'(gi));
    always_ff @(posedge clk or posedge sys_rst)
    begin
      if (sys_rst)
        bufData_r[gi] <= 8'h00;
      else if (entryWr)
        bufData_r[gi] <= pushData;
    end
  end

  // Fixed baud divider; timing of serial bits rides outside on txReady
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      baudDiv_r <= 16'h0000;
    else
      baudDiv_r <= 16'(BIT_CYC);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r    <= sbl_pkg::SBL_SEND_REQ;
      retState_r <= sbl_pkg::SBL_SEND_REQ;
    end
    else
    begin
      case (state_r)
        sbl_pkg::SBL_SEND_REQ:
        begin
          if (push)
          begin
            state_r    <= sbl_pkg::SBL_TX_WAIT;
            retState_r <= sbl_pkg::SBL_WAIT_ACK;
          end
        end
        sbl_pkg::SBL_TX_WAIT:
        begin
          if (bufEmpty)
            state_r <= retState_r;
        end
        sbl_pkg::SBL_WAIT_ACK:
        begin
          if (ackSeen)
            state_r <= sbl_pkg::SBL_GET_PAIR;
          else if (timedOut)
            state_r <= sbl_pkg::SBL_RUN_APP;
        end
        sbl_pkg::SBL_GET_PAIR:
        begin
          if (lastByte)
            state_r <= sbl_pkg::SBL_VPP_ON;
        end
        sbl_pkg::SBL_VPP_ON:
        begin
          state_r <= sbl_pkg::SBL_WRITE;
        end
        sbl_pkg::SBL_WRITE:
        begin
          if (pulseDone)
            state_r <= sbl_pkg::SBL_VPP_OFF;
        end
        sbl_pkg::SBL_VPP_OFF:
        begin
          state_r <= sbl_pkg::SBL_READ;
        end
        sbl_pkg::SBL_READ:
        begin
          state_r <= sbl_pkg::SBL_REPLY;
        end
        sbl_pkg::SBL_REPLY:
        begin
          if (push)
          begin
            state_r    <= sbl_pkg::SBL_TX_WAIT;
            retState_r <= sbl_pkg::SBL_GET_PAIR;
          end
        end
        sbl_pkg::SBL_RUN_APP:
        begin
          state_r <= sbl_pkg::SBL_RUN_APP;
        end
        default:
        begin
          state_r <= sbl_pkg::SBL_SEND_REQ;
        end
      endcase
    end
  end

  // Wait counter: ack time-out and write pulse length
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      waitCnt_r <= 32'h0000_0000;
    else if (inTxWait || inVppOn)
      waitCnt_r <= 32'h0000_0000;
    else if (inWaitAck || inWrite)
      waitCnt_r <= waitCnt_r + 32'h0000_0001;
  end

  // Programming-voltage enable, low for exactly PULSE_CYC+1 cycles
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      vppEnableOut_n <= 1'b1;
    else if (inVppOn)
      vppEnableOut_n <= 1'b0;
    else if (inVppOff)
      vppEnableOut_n <= 1'b1;
  end

  // Address and data bytes of one location
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tablePointer_r <= 16'h0000;
      tableLatch_r   <= 16'h0000;
    end
    else if (inGetPair && rxTake)
    begin
      case (byteCnt_r)
        2'd0: tablePointer_r[15:8] <= rxData;
        2'd1: tablePointer_r[7:0]  <= rxData;
        2'd2: tableLatch_r[15:8]   <= rxData;
        default: tableLatch_r[7:0] <= rxData;
      endcase
    end
  end

  // Byte position inside the four-byte pair
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      byteCnt_r <= 2'd0;
    else if (ackSeen || (inReply && push))
      byteCnt_r <= 2'd0;
    else if (inGetPair && rxTake)
      byteCnt_r <= byteCnt_r + 2'd1;
  end

  // Read-back of the written location
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      readBack_r <= 16'h0000;
    else if (inRead)
      readBack_r <= mem[memIdx];
  end

  // Sticky status flags
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      appStart_r  <= 1'b0;
      progError_r <= 1'b0;
    end
    else
    begin
      if (inRunApp)
        appStart_r <= 1'b1;
      if (inReply && push && !verifyOk)
        progError_r <= 1'b1;
    end
  end
endmodule // sbl_boot_loader

// file: verification/sbl_host_model.sv
// Host side of the serial programming link
`timescale 1ns/1ns
module sbl_host_model (
  input  wire logic       clk,
  input  wire logic       slow,
  output logic [7:0]      rxData,
  output logic            rxValid,
  input  wire logic       rxReady,
  input  wire logic [7:0] txData,
  input  wire logic       txValid,
  output logic            txReady
);
  logic [7:0] got[$];
  logic       ph = 1'b0;
  initial {rxData, rxValid, txReady} = 10'h001;
  always @(negedge clk)
  begin
    ph <= ~ph;
    txReady <= ~slow | ph;
  end
  always @(posedge clk)
    if (txValid && txReady) got.push_back(txData);
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    @(negedge clk);
    rxData = b;
    rxValid = 1'b1;
    while (!rxReady && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    rxValid = 1'b0;
    rxData = ~b;
  endtask
endmodule // sbl_host_model

// file: verification/sbl_boot_loader_assertions.sv
// Port checks for the boot loader
`timescale 1ns/1ns
module sbl_boot_loader_assertions #(parameter int PULSE_CYC = 20) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        rxValid,
  input wire logic        rxReady,
  input wire logic [7:0]  txData,
  input wire logic        txValid,
  input wire logic        txReady,
  input wire logic        vppEnableOut_n,
  input wire logic [15:0] bootVector,
  input wire logic        appStart,
  input wire logic        progError,
  input wire logic [15:0] fetchWord,
  input wire logic        fetchNop
);
  logic [31:0] lowCnt_r;
  logic        reqSeen_r;
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      lowCnt_r  <= '0;
      reqSeen_r <= 1'b0;
    end
    else
    begin
      lowCnt_r  <= vppEnableOut_n ? 32'h0 : lowCnt_r + 32'h1;
      reqSeen_r <= reqSeen_r | (txValid & txReady);
    end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence pairDone;
    rxValid && rxReady ##1 !rxReady;
  endsequence
  pulse_len_a: assert property ($rose(vppEnableOut_n) |-> lowCnt_r == PULSE_CYC + 1)
    else $error("pulse length wrong");
  vpp_on_a: assert property (pairDone |-> ##[0:3] !vppEnableOut_n)
    else $error("vpp not enabled");
  rx_hold_a: assert property (!vppEnableOut_n |-> !rxReady)
    else $error("rx open in write");
  boot_vec_a: assert property (bootVector == 16'h0700)
    else $error("boot vector wrong");
  nop_word_a: assert property (fetchNop == (fetchWord == 16'h0000))
    else $error("nop decode wrong");
  first_req_a: assert property (txValid && !reqSeen_r |-> txData == 8'h52)
    else $error("first byte not request");
  app_idle_a: assert property (appStart |-> vppEnableOut_n && !rxReady)
    else $error("app run while loading");
  err_flag_a: assert property (txValid && txData == 8'h15 |-> ##[0:4] progError)
    else $error("error flag missing");
endmodule // sbl_boot_loader_assertions
bind sbl_boot_loader sbl_boot_loader_assertions #(.PULSE_CYC(PULSE_CYC)) chk_i (.*);

// file: verification/tb.sv
// Testbench for the boot loader
`timescale 1ns/1ns
module tb;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        slow = 1'b0;
  logic [15:0] fetchAddr = 16'h0000;
  logic [7:0]  rxData, txData;
  logic        rxValid, rxReady, txValid, txReady;
  logic        vppEnableOut_n, appStart, progError, fetchNop;
  logic [15:0] bootVector, fetchWord;
  int          fail_count = 0;
  int          num_checks = 0;
  always #10 clk = ~clk;
  sbl_boot_loader #(.TIMEOUT_CYC(200), .PULSE_CYC(20)) dut (.*);
  sbl_host_model host (.*);
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wait_tx(input int k);
    int n;
    n = 0;
    while (host.got.size() <= k && n < 500)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic do_reset();
    @(negedge clk);
    sys_rst = 1'b1;
    host.got.delete();
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    wait_tx(0);
    chk("request", {8'h00, host.got[0]}, 16'h0052);
    chk("appStart", appStart, 16'h0000);
  endtask
  task automatic prog(input logic [15:0] a, input logic [15:0] d, input logic [7:0] r);
    int k;
    k = host.got.size();
    host.send(a[15:8]);
    host.send(a[7:0]);
    host.send(d[15:8]);
    host.send(d[7:0]);
    wait_tx(k);
    chk("reply", {8'h00, host.got[k]}, {8'h00, r});
  endtask
  task automatic look(input logic [15:0] a, input logic [15:0] e);
    fetchAddr = a;
    @(negedge clk);
    chk("fetchWord", fetchWord, e);
  endtask
  task automatic t_timeout();
    int n;
    n = 0;
    do_reset();
    while (!appStart && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    chk("appStart", appStart, 16'h0001);
    chk("vpp", vppEnableOut_n, 16'h0001);
    chk("bootVector", bootVector, 16'h0700);
  endtask
  task automatic t_update();
    do_reset();
    host.send(8'h33);
    host.send(8'h41);
    slow = 1'b1;
    prog(16'h0000, 16'h0000, 8'h06);
    prog(16'h0001, 16'h2860, 8'h06);
    look(16'h0000, 16'h0000);
    chk("fetchNop", fetchNop, 16'h0001);
    look(16'h0001, 16'h2860);
    look(16'h0002, 16'hffff);
    prog(16'h0001, 16'hffff, 8'h15);
    chk("progError", progError, 16'h0001);
    look(16'h0001, 16'h2860);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    finish_test();
  end
  initial
  begin
    t_timeout();
    t_update();
    finish_test();
  end
endmodule // tb
